/* File: nor_bypass_host.v */
// host controller: issues command sequences and auto-select reads to a parallel nor flash
// assumes flash is in word mode and strobes are asynchronous pins driven from sys_clk
`timescale 1ns/100ps
`include "nor_bypass_host_map.vh"
module nor_bypass_host #(
  parameter ADDR_W = 24,
  parameter HIGH_VARIANT = 0
) (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // user commands
  input wire [2:0] cmdOp,
  input wire [ADDR_W-1:0] cmdAddr,
  input wire [15:0] cmdData,
  input wire cmdValid,
  output wire cmdReady,
  input wire vppRaiseReq,
  output reg [15:0] rdData_q,
  output reg rdDone_q,
  output reg protStatus_q,
  output reg extLocked_q,
  output reg inBypass_q,
  output reg inAutoSel_q,
  output reg vppHigh_q,
  // flash pins
  output reg chipSelN_q,
  output reg outEnN_q,
  output reg writeEnN_q,
  output reg [ADDR_W-1:0] addr_q,
  output reg [15:0] dqOut_q,
  output reg dqOe_n_q,
  input wire [15:0] dqIn
);
  // user ops
  localparam OP_READ = 3'h0;
  localparam OP_AUTOSEL = 3'h1;
  localparam OP_BYPASS = 3'h2;
  localparam OP_BYP_RST = 3'h3;
  localparam OP_READRST = 3'h4;
  localparam OP_PROG = 3'h5;
  localparam OP_BPS = 3'h6;
  localparam OP_EXT = 3'h7;
  // states
  localparam S_IDLE = 2'h0;
  localparam S_SETUP = 2'h1;
  localparam S_STROBE = 2'h2;
  localparam S_GAP = 2'h3;
  localparam integer STROBE_CYC = `T_STROBE_CYC;

  reg rstMeta_q;
  reg rstSync_q;
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire rstN = rstSync_q;

  reg [15:0] dqMeta_q;
  reg [15:0] dqSync_q;
  always @(posedge sys_clk)
  begin
    dqMeta_q <= dqIn;
    dqSync_q <= dqMeta_q;
  end

  reg [1:0] state_q;
  reg [2:0] op_q;
  reg [1:0] step_q;
  reg [1:0] lastStep_q;
  reg [7:0] cnt_q;
  reg [ADDR_W-1:0] uAddr_q;
  reg [15:0] uData_q;
  reg isRead;
  reg [ADDR_W-1:0] cycAddr;
  reg [15:0] cycData;
  reg [1:0] nSteps;

  assign cmdReady = (state_q == S_IDLE);

  // address and data of each bus cycle in a sequence
  always @*
  begin
    isRead = 1'b0;
    cycAddr = `ADR_UNLOCK1;
    cycData = `CMD_UNLOCK1;
    nSteps = 2'd0;
    case (op_q)
      OP_READ:
      begin
        isRead = 1'b1;
        cycAddr = uAddr_q;
      end
      OP_AUTOSEL, OP_BYPASS:
      begin
        nSteps = 2'd2;
        if (step_q == 2'd1)
        begin
          cycAddr = `ADR_UNLOCK2;
          cycData = `CMD_UNLOCK2;
        end
        else if (step_q == 2'd2)
        begin
          cycData = (op_q == OP_BYPASS) ? `CMD_BYPASS : `CMD_AUTOSEL;
        end
      end
      OP_BYP_RST:
      begin
        nSteps = 2'd1;
        cycAddr = uAddr_q;
        cycData = (step_q == 2'd0) ? `CMD_BYP_RST1 : `CMD_BYP_RST2;
      end
      OP_READRST:
      begin
        cycAddr = uAddr_q;
        cycData = `CMD_READRST;
      end
      // in bypass only setup and data, else full four-write program
      OP_PROG:
      begin
        nSteps = inBypass_q ? 2'd1 : 2'd3;
        if (!inBypass_q && step_q == 2'd1)
        begin
          cycAddr = `ADR_UNLOCK2;
          cycData = `CMD_UNLOCK2;
        end
        else if (step_q == nSteps)
        begin
          cycAddr = uAddr_q;
          cycData = uData_q;
        end
        else if (inBypass_q || step_q == 2'd2)
        begin
          cycData = `CMD_PROGRAM;
        end
      end
      // block base on upper bits, A1 high, A0 low
      OP_BPS:
      begin
        isRead = 1'b1;
        cycAddr = {uAddr_q[ADDR_W-1:`BLK_BASE_LSB], {`BLK_BASE_LSB{1'b0}}} | `ADR_BPS_OFS;
      end
      default:
      begin
        isRead = 1'b1;
        cycAddr = `ADR_EXT_OFS;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_q <= S_IDLE;
      op_q <= OP_READ;
      step_q <= 2'd0;
      lastStep_q <= 2'd0;
      cnt_q <= 8'h00;
      uAddr_q <= {ADDR_W{1'b0}};
      uData_q <= 16'h0000;
      rdData_q <= 16'h0000;
      rdDone_q <= 1'b0;
      protStatus_q <= 1'b0;
      extLocked_q <= 1'b0;
      inBypass_q <= 1'b0;
      inAutoSel_q <= 1'b0;
      vppHigh_q <= 1'b0;
      chipSelN_q <= 1'b1;
      outEnN_q <= 1'b1;
      writeEnN_q <= 1'b1;
      addr_q <= {ADDR_W{1'b0}};
      dqOut_q <= 16'h0000;
      dqOe_n_q <= 1'b1;
    end
    else
    begin
      rdDone_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          // raise program voltage only from plain read mode
          if (vppRaiseReq && !vppHigh_q && !inBypass_q && !inAutoSel_q)
          begin
            vppHigh_q <= 1'b1;
            inBypass_q <= 1'b1;
          end
          else if (!vppRaiseReq && vppHigh_q)
          begin
            vppHigh_q <= 1'b0;
            inBypass_q <= 1'b0;
          end
          else if (cmdValid)
          begin
            op_q <= cmdOp;
            uAddr_q <= cmdAddr;
            uData_q <= cmdData;
            step_q <= 2'd0;
            state_q <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          lastStep_q <= nSteps;
          addr_q <= cycAddr;
          dqOut_q <= cycData;
          chipSelN_q <= 1'b0;
          dqOe_n_q <= isRead;
          cnt_q <= STROBE_CYC[7:0];
          state_q <= S_STROBE;
        end
        S_STROBE:
        begin
          outEnN_q <= !isRead;
          writeEnN_q <= isRead;
          if (cnt_q != 8'h00)
          begin
            cnt_q <= cnt_q - 8'h01;
          end
          else
          begin
            outEnN_q <= 1'b1;
            writeEnN_q <= 1'b1;
            state_q <= S_GAP;
            if (isRead)
            begin
              rdData_q <= dqSync_q;
              rdDone_q <= 1'b1;
              if (op_q == OP_BPS)
                protStatus_q <= (dqSync_q == `BPS_PROT);
              if (op_q == OP_EXT)
                extLocked_q <= dqSync_q[`EXT_LOCK_BIT];
            end
          end
        end
        default:
        begin
          chipSelN_q <= 1'b1;
          dqOe_n_q <= 1'b1;
          if (step_q != lastStep_q)
          begin
            step_q <= step_q + 2'd1;
            state_q <= S_SETUP;
          end
          else
          begin
            state_q <= S_IDLE;
            if (op_q == OP_AUTOSEL && !inBypass_q)
              inAutoSel_q <= 1'b1;
            // read/reset leaves auto-select but not bypass
            if (op_q == OP_READRST)
              inAutoSel_q <= 1'b0;
            if (op_q == OP_BYPASS && !inAutoSel_q)
              inBypass_q <= 1'b1;
            // bypass reset returns to read mode unless program voltage is high
            if (op_q == OP_BYP_RST && !vppHigh_q)
              inBypass_q <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule // nor_bypass_host

/* File: nor_bypass_host_map.vh */
// constants for the host that drives the parallel flash's bypass and protect readout commands
// assumes standard unlock addresses 555h/2aah in word mode
`ifndef NOR_BYPASS_HOST_MAP_VH
`define NOR_BYPASS_HOST_MAP_VH
// command codes
`define CMD_UNLOCK1 16'h00aa
`define CMD_UNLOCK2 16'h0055
`define CMD_AUTOSEL 16'h0090
`define CMD_BYPASS 16'h0020
`define CMD_READRST 16'h00f0
`define CMD_BYP_RST1 16'h0090
`define CMD_BYP_RST2 16'h0000
`define CMD_PROGRAM 16'h00a0
// unlock addresses
`define ADR_UNLOCK1 24'h000555
`define ADR_UNLOCK2 24'h0002aa
// auto-select offsets in the low address bits
`define ADR_BPS_OFS 24'h000002
`define ADR_EXT_OFS 24'h000003
`define BLK_BASE_LSB 16
// readout values
`define BPS_PROT 16'h0001
`define BPS_UNPROT 16'h0000
`define EXT_LO_LOCKED 16'h0089
`define EXT_LO_OPEN 16'h0009
`define EXT_HI_LOCKED 16'h0099
`define EXT_HI_OPEN 16'h0019
`define EXT_LOCK_BIT 7
// bus timing, ns, and cycles at 4 ns
`define T_CLK_NS 4
`define T_STROBE_NS 70
`define T_STROBE_CYC ((`T_STROBE_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`endif

/* File: nor_bypass_host_properties.sv */
// checker of the flash host pins and mode flags
// assumes binding into nor_bypass_host
`timescale 1ns/100ps
module nor_bypass_host_properties #(parameter ADDR_W = 24) (
  // clock and reset
  input logic sys_clk,
  input logic arst_n,
  // flags
  input logic rdDone_q,
  input logic inBypass_q,
  input logic inAutoSel_q,
  input logic vppHigh_q,
  // pins
  input logic chipSelN_q,
  input logic outEnN_q,
  input logic writeEnN_q,
  input logic [ADDR_W-1:0] addr_q,
  input logic dqOe_n_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence readLow;
    !outEnN_q [*8];
  endsequence
  a_strobe_needs_cs:
    assert property ((!outEnN_q || !writeEnN_q) |-> !chipSelN_q) else $error("no select");
  a_strobes_exclusive:
    assert property (outEnN_q || writeEnN_q) else $error("both strobes");
  a_write_drives_dq:
    assert property (!writeEnN_q |-> !dqOe_n_q) else $error("write undriven");
  a_read_releases_dq:
    assert property (!outEnN_q |-> dqOe_n_q) else $error("read while driving");
  a_read_completes:
    assert property ($fell(outEnN_q) |-> readLow ##[1:20] rdDone_q) else $error("read late");
  a_write_addr_held:
    assert property ($fell(writeEnN_q) |=> $stable(addr_q) [*8]) else $error("addr moved");
  a_vpp_from_read:
    assert property ($rose(vppHigh_q) |-> !$past(inBypass_q) && !$past(inAutoSel_q))
      else $error("vpp outside read");
  a_vpp_gives_bypass:
    assert property ($rose(vppHigh_q) |-> ##[0:2] inBypass_q) else $error("no bypass");
  a_vpp_drop_exits:
    assert property ($fell(vppHigh_q) |-> !inBypass_q) else $error("bypass kept");
  a_bypass_exit_cause:
    assert property ($fell(inBypass_q) |-> $fell(vppHigh_q) || !$past(chipSelN_q))
      else $error("bypass left without cause");
endmodule // nor_bypass_host_properties
bind nor_bypass_host nor_bypass_host_properties #(.ADDR_W(ADDR_W)) chk (.*);

/* File: flash_model.sv */
// behavioural flash: command decode, protect readout, bypass mode
// assumes word mode; writes latch on the rising write strobe
`timescale 1ns/100ps
module flash_model #(parameter HIGH_VAR = 0) (
  // strobes
  input wire chipSelN,
  input wire outEnN,
  input wire writeEnN,
  input wire vpp,
  // bus
  input wire [23:0] addr,
  input wire [15:0] dq,
  output wire [15:0] dqDrv
);
  reg [15:0] mem [0:255];
  reg [15:0] rd;
  reg [1:0] step;
  reg autoSel, bypCmd, prog, bypRst;
  integer i;
  wire byp = bypCmd | vpp;
  // released bus shows inverted data
  assign dqDrv = (!chipSelN && !outEnN) ? rd : ~rd;
  initial
  begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = {i[7:0], ~i[7:0]};
    {step, autoSel, bypCmd, prog, bypRst} = 0;
  end
  always @(negedge vpp)
    bypCmd = 1'b0;
  always @*
  begin
    rd = mem[addr[7:0]];
    if (autoSel && addr[7:5] == 3'h0 && addr[3:2] == 2'h0 && addr[1])
      rd = addr[0] ? {8'h00, 3'h4, HIGH_VAR[0], 4'h9} : {15'h0000, addr[16]};
  end
  always @(posedge writeEnN)
    if (!chipSelN)
    begin
      if (prog)
      begin
        mem[addr[7:0]] = mem[addr[7:0]] & dq;
        prog = 0;
      end
      // bypass takes program and reset only
      else if (byp)
      begin
        prog = (dq == 16'h00a0);
        bypCmd = bypCmd & !(bypRst && dq == 16'h0000);
        bypRst = (dq == 16'h0090);
      end
      else if (dq == 16'h00f0)
        {step, autoSel} = 0;
      else if (step == 2'h2 && addr[11:0] == 12'h555)
      begin
        autoSel = autoSel | (dq == 16'h0090);
        bypCmd = (dq == 16'h0020);
        prog = (dq == 16'h00a0);
        step = 0;
      end
      else
        step = (step == 2'h0 && dq == 16'h00aa) ? 2'h1 : (step == 2'h1 && dq == 16'h0055) ? 2'h2 : 2'h0;
    end
endmodule // flash_model

/* File: tb_nor_bypass_host.sv */
// bench of the flash host: random and corner commands against a flash model
// assumes the model behind the pins
`timescale 1ns/100ps
module tb_nor_bypass_host;
  reg sysClk, arstN, cmdValid, vppReq;
  reg [2:0] cmdOp;
  reg [23:0] cmdAddr;
  reg [15:0] cmdData, rnd;
  wire cmdReady, rdDone, prot, extL, inByp, inAuto, high_program_voltage_level, csN, oeN, weN, dqOeN;
  wire [23:0] addr;
  wire [15:0] rdData, dqOut, flashDq;
  wire [15:0] dq = dqOeN ? flashDq : dqOut;
  integer fails = 0, testsRun = 0, dones = 0, n, k;
  nor_bypass_host dut (.sys_clk(sysClk), .arst_n(arstN), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdValid(cmdValid), .cmdReady(cmdReady), .vppRaiseReq(vppReq),
    .rdData_q(rdData), .rdDone_q(rdDone), .protStatus_q(prot), .extLocked_q(extL),
    .inBypass_q(inByp), .inAutoSel_q(inAuto), .vppHigh_q(high_program_voltage_level), .chipSelN_q(csN),
    .outEnN_q(oeN), .writeEnN_q(weN), .addr_q(addr), .dqOut_q(dqOut), .dqOe_n_q(dqOeN),
    .dqIn(dq));
  flash_model flash (.chipSelN(csN), .outEnN(oeN), .writeEnN(weN), .vpp(high_program_voltage_level),
    .addr(addr), .dq(dq), .dqDrv(flashDq));
  initial
  begin
    sysClk = 0;
    forever #2 sysClk = ~sysClk;
  end
  // one count per read-done pulse
  always @(negedge sysClk)
    if (rdDone === 1'b1)
      dones = dones + 1;
  initial
  begin
    #100000 fails = fails + 1;
    final_report;
  end
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [15:0] arr(input [7:0] a);
    arr = {a, ~a};
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
  begin
    testsRun = testsRun + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task chkF(input string nm, input e, input g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task op(input [2:0] o, input [23:0] a, input [15:0] d);
  begin
    @(negedge sysClk);
    {cmdOp, cmdAddr, cmdData, cmdValid} = {o, a, d, 1'b1};
    for (k = 0; k < 99 && cmdReady !== 1'b1; k = k + 1)
      @(negedge sysClk);
    @(negedge sysClk);
    cmdValid = 0;
    for (k = 0; k < 999 && cmdReady !== 1'b1; k = k + 1)
      @(negedge sysClk);
  end
  endtask
  task vpp(input v);
  begin
    @(negedge sysClk);
    vppReq = v;
    repeat (8) @(negedge sysClk);
  end
  endtask
  task final_report;
  begin
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  initial
  begin
    {cmdValid, vppReq, cmdOp, cmdAddr, cmdData, arstN} = 0;
    rnd = 16'h004b;
    repeat (4) @(negedge sysClk);
    arstN = 1;
    repeat (3) @(negedge sysClk);
    op(1, 0, 0);
    chkF("autoSelOn", 1'b1, inAuto);
    for (n = 0; n < 2; n = n + 1)
    begin
      rnd = lfsr(rnd);
      op(6, {7'h00, n[0], rnd[5:0], 10'h002}, 0);
      chk("status", {15'h0000, n[0]}, rdData);
      chkF("statusFlag", n[0], prot);
    end
    op(7, 24'h000003, 0);
    chk("ext", 16'h0089, rdData);
    chkF("extFlag", 1'b1, extL);
    op(4, 0, 0);
    chkF("autoSel", 1'b0, inAuto);
    op(2, 0, 0);
    chkF("bypass", 1'b1, inByp);
    for (n = 0; n < 4; n = n + 1)
    begin
      rnd = lfsr(rnd);
      op(5, {22'h000020, n[1:0]}, rnd);
      op(0, {22'h000020, n[1:0]}, 0);
      chk("bypRead", arr({6'h20, n[1:0]}) & rnd, rdData);
    end
    op(4, 0, 0);
    chkF("bypHold", 1'b1, inByp);
    op(3, 0, 0);
    chkF("bypExit", 1'b0, inByp);
    vpp(1);
    chkF("vppByp", 1'b1, inByp);
    op(5, 24'h0000c0, rnd);
    op(0, 24'h0000c0, 0);
    chk("vppRead", arr(8'hc0) & rnd, rdData);
    vpp(0);
    chkF("vppExit", 1'b0, inByp);
    op(1, 0, 0);
    vpp(1);
    chkF("vppRefused", 1'b0, high_program_voltage_level);
    vpp(0);
    chk("readDone", 16'h0008, dones[15:0]);
    final_report;
  end
endmodule // tb_nor_bypass_host
